//--- hw/pcc_ctrl.sv
// pwm counter and capture control unit with register port and interrupt
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/1ns
`include "pcc_consts.svh"
module pcc_ctrl #(
	parameter int CNT_W = 16
) (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [7:0] rdata,
	input wire logic capture_in,
	input wire logic pwm_level,
	input wire logic fifth_pulse_in,
	output logic fifth_pulse_out,
	output logic fifth_pulse_oe,
	output logic fifth_pulse_pin_level,
	output logic irq
);
	logic [7:0] ctrl;
	logic [7:0] next_ctrl;
	logic [1:0] pincfg;
	logic [1:0] next_pincfg;
	logic [`PCC_ST_WIDTH-1:0] status;
	logic [`PCC_ST_WIDTH-1:0] next_status;
	logic [`PCC_ST_WIDTH-1:0] mask;
	logic [`PCC_ST_WIDTH-1:0] next_mask;
	logic [CNT_W-1:0] count;
	logic [CNT_W-1:0] next_count;
	logic [CNT_W-1:0] cap_val;
	logic [CNT_W-1:0] next_cap_val;
	logic [7:0] next_rdata;
	logic cap_s1, cap_s2, cap_prev;
	logic pin_s1, pin_s2;
	logic next_out, next_oe, next_irq;
	logic [2:0] pre_code;
	logic cnt_en, cap_ie, tick, cap_event, wrap_event;
	pcc_pkg::pcc_cap_mode_t cap_mode;
	pcc_pkg::pcc_pin_mode_t pin_mode;
	logic [`PCC_ST_WIDTH-1:0] events;

	// field decode of the control register
	assign pre_code = {ctrl[`PCC_BIT_PRE_MSB], ctrl[`PCC_BIT_PRE_MID],
		ctrl[`PCC_BIT_PRE_LSB]};
	assign cnt_en = ctrl[`PCC_BIT_CNT_EN];
	assign cap_ie = ctrl[`PCC_BIT_CAP_IE];
	assign cap_mode = pcc_pkg::pcc_cap_mode_t'(ctrl[1:0]);
	assign pin_mode = pcc_pkg::pcc_pin_mode_t'(pincfg);

	pcc_prescaler #(.PRE_W(3)) u_pre (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.run(cnt_en),
		.code(pre_code),
		.tick(tick)
	);

	// pin inputs pass two flops; the edge detector compares the second with a third flop, cap_prev
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			cap_s1 <= 1'b0;
			cap_s2 <= 1'b0;
			cap_prev <= 1'b0;
			pin_s1 <= 1'b0;
			pin_s2 <= 1'b0;
		end else begin
			cap_s1 <= capture_in;
			cap_s2 <= cap_s1;
			cap_prev <= cap_s2;
			pin_s1 <= fifth_pulse_in;
			pin_s2 <= pin_s1;
		end
	end

	// capture edge select
	always_comb begin
		case (cap_mode)
			pcc_pkg::PCC_CAP_FALL: cap_event = cap_prev & ~cap_s2;
			pcc_pkg::PCC_CAP_RISE: cap_event = ~cap_prev & cap_s2;
			pcc_pkg::PCC_CAP_BOTH: cap_event = cap_prev ^ cap_s2;
			default: cap_event = 1'b0;
		endcase
	end

	// counter wraps to zero at all ones; wrap is reported as an event
	assign wrap_event = tick & cnt_en & (&count);
	// capture only raises its status bit with the interrupt enable set
	assign events = {wrap_event, cap_event & cap_ie};

	// register writes, counter and capture; a set beats a same-cycle clear
	always_comb begin
		next_ctrl = ctrl;
		next_pincfg = pincfg;
		next_mask = mask;
		next_status = status;
		next_count = count;
		next_cap_val = cap_val;
		if (wr) begin
			case (addr)
				`PCC_ADDR_CTRL: next_ctrl = wdata & `PCC_CTRL_WMASK;
				`PCC_ADDR_PINCFG: next_pincfg = wdata[1:0];
				`PCC_ADDR_MASK: next_mask = wdata[`PCC_ST_WIDTH-1:0];
				`PCC_ADDR_STATUS: next_status = status & ~wdata[`PCC_ST_WIDTH-1:0];
				default: ;
			endcase
		end
		next_status = next_status | events;
		if (tick && cnt_en) begin
			next_count = count + 1'b1;
		end
		if (cap_event) begin
			next_cap_val = count;
		end
	end

	// read mux: data stand in the cycle after the strobe only
	always_comb begin
		next_rdata = 8'h00;
		if (rd) begin
			case (addr)
				`PCC_ADDR_CTRL: next_rdata = ctrl;
				`PCC_ADDR_PINCFG: next_rdata = {6'h00, pincfg};
				`PCC_ADDR_STATUS: next_rdata = {6'h00, status};
				`PCC_ADDR_MASK: next_rdata = {6'h00, mask};
				`PCC_ADDR_CAPLO: next_rdata = cap_val[7:0];
				`PCC_ADDR_CAPHI: next_rdata = cap_val[CNT_W-1:CNT_W-8];
				`PCC_ADDR_CNTLO: next_rdata = count[7:0];
				`PCC_ADDR_CNTHI: next_rdata = count[CNT_W-1:CNT_W-8];
				default: next_rdata = 8'h00;
			endcase
		end
	end

	// fifth pin: open-drain only pulls low, push-pull drives the level
	always_comb begin
		next_out = 1'b0;
		next_oe = 1'b0;
		case (pin_mode)
			pcc_pkg::PCC_PIN_OD: begin
				next_out = 1'b0;
				next_oe = ~pwm_level;
			end
			pcc_pkg::PCC_PIN_PP: begin
				next_out = pwm_level;
				next_oe = 1'b1;
			end
			default: begin
				next_out = 1'b0;
				next_oe = 1'b0;
			end
		endcase
		next_irq = |(next_status & next_mask);
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			ctrl <= `PCC_CTRL_RESET;
			pincfg <= `PCC_PINCFG_RESET;
			status <= '0;
			mask <= '0;
			count <= '0;
			cap_val <= '0;
			rdata <= 8'h00;
			fifth_pulse_out <= 1'b0;
			fifth_pulse_oe <= 1'b0;
			fifth_pulse_pin_level <= 1'b0;
			irq <= 1'b0;
		end else begin
			ctrl <= next_ctrl;
			pincfg <= next_pincfg;
			status <= next_status;
			mask <= next_mask;
			count <= next_count;
			cap_val <= next_cap_val;
			rdata <= next_rdata;
			fifth_pulse_out <= next_out;
			fifth_pulse_oe <= next_oe;
			fifth_pulse_pin_level <= pin_s2;
			irq <= next_irq;
		end
	end

	// bit 2 of the control register never holds a one
	a_bit2_unused: assert property (@(posedge clk_sys) disable iff (sys_rst)
		!ctrl[2]) else $error("unused control bit set");

	// counter stands still with the enable clear
	a_count_hold: assert property (@(posedge clk_sys) disable iff (sys_rst)
		!cnt_en |=> count == $past(count)) else $error("counter moved while off");

	// divide by code plus one: ticks spaced code plus one cycles
	a_tick_spacing: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(tick && cnt_en && pre_code == 3'h7 && $stable(ctrl)) |=>
		(!tick)[*7] ##1 (tick || !cnt_en || !$stable(ctrl)))
		else $error("prescale spacing wrong");

	// undivided code ticks every cycle
	a_tick_full: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(cnt_en && pre_code == 3'h0 && $past(cnt_en) && $past(pre_code) == 3'h0
		&& $past(cnt_en, 2)) |-> tick) else $error("no tick at divide one");

	// rising only mode never captures on a falling edge
	a_cap_rise: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(cap_mode == pcc_pkg::PCC_CAP_RISE && cap_prev && !cap_s2) |-> !cap_event)
		else $error("capture on wrong edge");

	// capture disabled: captured value stays put
	a_cap_off: assert property (@(posedge clk_sys) disable iff (sys_rst)
		cap_mode == pcc_pkg::PCC_CAP_OFF |=> cap_val == $past(cap_val))
		else $error("capture while disabled");

	// capture status needs the interrupt enable
	a_cap_status: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(cap_event && cap_ie) |=> status[`PCC_ST_CAPTURE])
		else $error("capture status not set");

	// pin drive follows the configuration one cycle later
	a_pin_drive: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(pin_mode == pcc_pkg::PCC_PIN_PP) |=>
		(fifth_pulse_oe && fifth_pulse_out == $past(pwm_level)))
		else $error("push-pull pin not driven");

	// input codes leave the pin undriven
	a_pin_input: assert property (@(posedge clk_sys) disable iff (sys_rst)
		!pincfg[1] |=> !fifth_pulse_oe) else $error("input pin driven");

	// open-drain only pulls low, and only while the pwm level is low
	a_od_drive: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(pin_mode == pcc_pkg::PCC_PIN_OD) |=>
		(!fifth_pulse_out && fifth_pulse_oe == !$past(pwm_level)))
		else $error("open-drain pin drive wrong");

	// pin code writes land the cycle after the strobe
	a_pincfg_write: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(wr && addr == `PCC_ADDR_PINCFG) |=> pincfg == $past(wdata[1:0]))
		else $error("pin code write lost");

	// falling only mode never captures on a rising edge
	a_cap_fall: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(cap_mode == pcc_pkg::PCC_CAP_FALL && !cap_prev && cap_s2) |-> !cap_event)
		else $error("capture on wrong edge");

	// both edges mode takes every change of the synchronised input
	a_cap_both: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(cap_mode == pcc_pkg::PCC_CAP_BOTH && cap_prev != cap_s2) |-> cap_event)
		else $error("edge missed in both mode");

	// a captured edge stores the counter value of that very cycle
	a_cap_value: assert property (@(posedge clk_sys) disable iff (sys_rst)
		cap_event |=> cap_val == $past(count))
		else $error("captured value wrong");

	// without the interrupt enable a capture cannot raise its status bit
	a_cap_gate: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(!cap_ie && !status[`PCC_ST_CAPTURE]) |=> !status[`PCC_ST_CAPTURE])
		else $error("capture status set while disabled");

	// a counted tick moves the counter by exactly one
	a_count_step: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(tick && cnt_en) |=> count == $past(count) + 1'b1)
		else $error("counter step wrong");

	// prescaler goes quiet one cycle after the enable drops
	a_tick_idle: assert property (@(posedge clk_sys) disable iff (sys_rst)
		!cnt_en |=> !tick) else $error("tick while counter off");

	// counter rolls over to zero at all ones and reports the wrap
	a_wrap_event: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(tick && cnt_en && (&count)) |=> (count == '0 && status[`PCC_ST_WRAP]))
		else $error("wrap not reported");

	// control writes land with the unused bit masked off
	a_ctrl_write: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(wr && addr == `PCC_ADDR_CTRL) |=> ctrl == ($past(wdata) & `PCC_CTRL_WMASK))
		else $error("control write wrong");

	// control reads return the register with bit 2 as zero
	a_ctrl_read: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(rd && addr == `PCC_ADDR_CTRL) |=> (rdata == $past(ctrl) && !rdata[2]))
		else $error("control read wrong");

	// status reads show the sticky bits in the low positions
	a_status_read: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(rd && addr == `PCC_ADDR_STATUS) |=> rdata == {6'h00, $past(status)})
		else $error("status read wrong");

	// read data stand one cycle only, zero otherwise
	a_rdata_idle: assert property (@(posedge clk_sys) disable iff (sys_rst)
		!rd |=> rdata == 8'h00) else $error("read data without strobe");

	// writing a one clears the capture bit when no new event lands
	a_status_clear: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(wr && addr == `PCC_ADDR_STATUS && wdata[`PCC_ST_CAPTURE]
		&& !events[`PCC_ST_CAPTURE]) |=> !status[`PCC_ST_CAPTURE])
		else $error("status bit not cleared");

	// a same-cycle event beats the clear so no capture is lost
	a_set_wins: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(wr && addr == `PCC_ADDR_STATUS && events[`PCC_ST_CAPTURE])
		|=> status[`PCC_ST_CAPTURE]) else $error("clear beat the event");

	// interrupt is a level: high while any unmasked status bit is set
	a_irq_level: assert property (@(posedge clk_sys) disable iff (sys_rst)
		irq == |(status & mask)) else $error("interrupt level wrong");
endmodule // pcc_ctrl

//--- hw/pcc_consts.svh
// register offsets, field positions, reset values and the control write mask
`ifndef PCC_CONSTS_SVH
`define PCC_CONSTS_SVH
`define PCC_ADDR_CTRL 8'hF8
`define PCC_ADDR_PINCFG 8'hF9
`define PCC_ADDR_STATUS 8'hFA
`define PCC_ADDR_MASK 8'hFB
`define PCC_ADDR_CAPLO 8'hFC
`define PCC_ADDR_CAPHI 8'hFD
`define PCC_ADDR_CNTLO 8'hFE
`define PCC_ADDR_CNTHI 8'hFF
`define PCC_CTRL_RESET 8'h00
`define PCC_CTRL_WMASK 8'hFB
`define PCC_BIT_PRE_MSB 4
`define PCC_BIT_PRE_MID 7
`define PCC_BIT_PRE_LSB 6
`define PCC_BIT_CNT_EN 5
`define PCC_BIT_CAP_IE 3
`define PCC_PINCFG_RESET 2'h0
`define PCC_ST_CAPTURE 0
`define PCC_ST_WRAP 1
`define PCC_ST_WIDTH 2
`endif

//--- hw/pcc_pkg.sv
// types shared by the pwm counter and capture control block
package pcc_pkg;
	typedef enum logic [1:0] {
		PCC_CAP_OFF,
		PCC_CAP_FALL,
		PCC_CAP_RISE,
		PCC_CAP_BOTH
	} pcc_cap_mode_t;
	typedef enum logic [1:0] {
		PCC_PIN_IN0,
		PCC_PIN_IN1,
		PCC_PIN_OD,
		PCC_PIN_PP
	} pcc_pin_mode_t;
endpackage

//--- hw/pcc_prescaler.sv
// counter clock prescaler: one tick every code plus one cycles
`timescale 1ns/1ns
`include "pcc_consts.svh"
module pcc_prescaler #(
	parameter int PRE_W = 3
) (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic run,
	input wire logic [PRE_W-1:0] code,
	output logic tick
);
	logic [PRE_W-1:0] div_cnt;
	logic [PRE_W-1:0] next_div_cnt;
	logic next_tick;

	// count up to code, then tick and restart; held at zero when stopped
	always_comb begin
		next_div_cnt = '0;
		next_tick = 1'b0;
		if (run) begin
			if (div_cnt >= code) begin
				next_tick = 1'b1;
			end else begin
				next_div_cnt = div_cnt + 1'b1;
			end
		end
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			div_cnt <= '0;
			tick <= 1'b0;
		end else begin
			div_cnt <= next_div_cnt;
			tick <= next_tick;
		end
	end
endmodule // pcc_prescaler

//--- dv/pcc_far_end.sv
// far side model: capture signal source and fifth pwm pin with a pull-up
`timescale 1ns/1ns
module pcc_far_end (
	input wire logic clk_sys,
	input wire logic fifth_pulse_out,
	input wire logic fifth_pulse_oe,
	output logic capture_in,
	output logic pwm_level,
	output logic fifth_pulse_in
);
	// a released pin floats up through the external pull-up
	assign fifth_pulse_in = fifth_pulse_oe ? fifth_pulse_out : 1'b1;
	initial begin
		capture_in = 1'b0;
		pwm_level = 1'b0;
	end
	// changes land just after an edge, like any same-clock source
	task automatic set_cap(input logic v);
		@(posedge clk_sys) capture_in <= v;
	endtask
	task automatic set_pwm(input logic v);
		@(posedge clk_sys) pwm_level <= v;
	endtask
endmodule // pcc_far_end

//--- dv/pcc_ctrl_bench.sv
// self-checking bench for the pwm counter and capture control block
`timescale 1ns/1ns
`include "pcc_consts.svh"
module pcc_ctrl_bench;
	logic clk_sys, sys_rst, wr, rd, capture_in, pwm_level, fifth_pulse_in, exp;
	logic [7:0] addr, wdata, rdata, got, first;
	logic fifth_pulse_out, fifth_pulse_oe, fifth_pulse_pin_level, irq;
	int mismatches, checks;
	pcc_ctrl u_dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd), .rdata(rdata), .capture_in(capture_in), .pwm_level(pwm_level),
		.fifth_pulse_in(fifth_pulse_in), .fifth_pulse_out(fifth_pulse_out),
		.fifth_pulse_oe(fifth_pulse_oe), .fifth_pulse_pin_level(fifth_pulse_pin_level),
		.irq(irq));
	pcc_far_end u_far (.clk_sys(clk_sys), .fifth_pulse_out(fifth_pulse_out),
		.fifth_pulse_oe(fifth_pulse_oe), .capture_in(capture_in), .pwm_level(pwm_level),
		.fifth_pulse_in(fifth_pulse_in));
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	task automatic compare(input logic [7:0] g, input logic [7:0] e, input string what);
		checks++;
		if (g !== e) begin
			mismatches++;
			$display("unexpected at %0t: %s got %h want %h", $time, what, g, e);
		end
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk_sys);
		wr <= 1'b0;
	endtask
	// read data stand only in the cycle after the strobe
	task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk_sys);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk_sys);
		rd <= 1'b0;
		#1 d = rdata;
	endtask
	task automatic check_reg(input logic [7:0] a, input logic [7:0] e, input string what);
		rd_reg(a, got);
		compare(got, e, what);
		// read data must fall back to zero in the following cycle
		@(posedge clk_sys);
		#1 compare(rdata, 8'h00, "read data gone");
	endtask
	task automatic give_verdict;
		$display("mismatches %0d checks %0d", mismatches, checks);
		if (mismatches == 0 && checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// whole run is about 620 cycles, so this leaves wide margin
	initial begin
		repeat (6000) @(posedge clk_sys);
		mismatches++;
		give_verdict();
	end
	initial begin
		sys_rst = 1'b1;
		wr = 1'b0;
		rd = 1'b0;
		addr = 8'h00;
		wdata = 8'h00;
		repeat (10) @(posedge clk_sys);
		sys_rst <= 1'b0;
		check_reg(`PCC_ADDR_CTRL, `PCC_CTRL_RESET, "control reset");
		check_reg(8'h10, 8'h00, "unmapped read");
		wr_reg(`PCC_ADDR_CTRL, 8'hFF);
		check_reg(`PCC_ADDR_CTRL, 8'hFB, "unused bit");
		// reads spaced eight divided periods apart differ by eight
		for (int c = 0; c < 8; c++) begin
			wr_reg(`PCC_ADDR_CTRL, {c[1], c[0], 1'b1, c[2], 4'h0});
			rd_reg(`PCC_ADDR_CNTLO, first);
			repeat (8 * c + 6) @(posedge clk_sys);
			rd_reg(`PCC_ADDR_CNTLO, got);
			compare(got - first, 8'h08, "counter rate");
		end
		// let a tick already in flight settle before sampling
		wr_reg(`PCC_ADDR_CTRL, 8'h00);
		repeat (3) @(posedge clk_sys);
		rd_reg(`PCC_ADDR_CNTLO, first);
		repeat (20) @(posedge clk_sys);
		check_reg(`PCC_ADDR_CNTLO, first, "counter held");
		// every capture mode against a rising then a falling edge
		wr_reg(`PCC_ADDR_MASK, 8'h01);
		for (int m = 0; m < 4; m++) begin
			wr_reg(`PCC_ADDR_CTRL, 8'h08 | 8'(m));
			for (int e = 0; e < 2; e++) begin
				wr_reg(`PCC_ADDR_STATUS, 8'h03);
				u_far.set_cap(e == 0);
				repeat (8) @(posedge clk_sys);
				exp = (e == 0) ? m[1] : m[0];
				compare({7'h0, irq}, {7'h0, exp}, "capture irq");
				check_reg(`PCC_ADDR_STATUS, {7'h0, exp}, "capture status");
			end
		end
		wr_reg(`PCC_ADDR_CTRL, 8'h03);
		wr_reg(`PCC_ADDR_STATUS, 8'h03);
		u_far.set_cap(1'b1);
		repeat (8) @(posedge clk_sys);
		check_reg(`PCC_ADDR_STATUS, 8'h00, "irq enable off");
		wr_reg(`PCC_ADDR_CTRL, 8'h0B);
		wr_reg(`PCC_ADDR_MASK, 8'h00);
		u_far.set_cap(1'b0);
		repeat (8) @(posedge clk_sys);
		compare({7'h0, irq}, 8'h00, "masked irq");
		check_reg(`PCC_ADDR_STATUS, 8'h01, "masked status");
		// counter is frozen, so every capture stored this same value
		rd_reg(`PCC_ADDR_CNTLO, first);
		check_reg(`PCC_ADDR_CAPLO, first, "capture value low");
		rd_reg(`PCC_ADDR_CNTHI, first);
		check_reg(`PCC_ADDR_CAPHI, first, "capture value high");
		// each pin code with both pwm levels
		for (int p = 0; p < 8; p++) begin
			wr_reg(`PCC_ADDR_PINCFG, 8'(p >> 1));
			u_far.set_pwm(p[0]);
			repeat (6) @(posedge clk_sys);
			exp = (p >= 6) | (p == 4);
			compare({6'h0, fifth_pulse_oe, fifth_pulse_out},
				{6'h0, exp, (p >= 6) & p[0]}, "pin drive");
			compare({7'h0, fifth_pulse_pin_level}, {7'h0, ~exp | p[0]}, "pin level");
		end
		// mid-run reset must bring control, pin code, status and the counter back to their reset values
		sys_rst <= 1'b1;
		repeat (2) @(posedge clk_sys);
		sys_rst <= 1'b0;
		check_reg(`PCC_ADDR_CTRL, `PCC_CTRL_RESET, "control after reset");
		check_reg(`PCC_ADDR_PINCFG, {6'h00, `PCC_PINCFG_RESET}, "pin code after reset");
		compare({7'h0, fifth_pulse_oe}, 8'h00, "pin released after reset");
		check_reg(`PCC_ADDR_STATUS, 8'h00, "status after reset");
		check_reg(`PCC_ADDR_CNTLO, 8'h00, "counter after reset");
		give_verdict();
	end
endmodule // pcc_ctrl_bench
